/* File: logic/lcdii_defines.svh */
// offsets, reset values and timing counts of the lcd instruction interpreter
`ifndef LCDII_DEFINES_SVH
`define LCDII_DEFINES_SVH

`define LCDII_OFS_CMD     8'h00
`define LCDII_OFS_DATA    8'h04
`define LCDII_OFS_FLAGS   8'h08

`define LCDII_CLK_MHZ     20
`define LCDII_EXEC_US     72
`define LCDII_EXEC_CYC    (`LCDII_EXEC_US * `LCDII_CLK_MHZ)
`define LCDII_CNT_W       11

`define LCDII_SPACE_WORD  16'h2020
`define LCDII_CRAM_LAST   6'h3F
`define LCDII_HPOS_LAST   4'hF

`define LCDII_RST_ID      1'b1
`define LCDII_RST_DL      1'b1
`define LCDII_RST_RE      1'b0
`define LCDII_RST_SR      1'b0
`define LCDII_RST_WAKE    1'b1
`define LCDII_RST_GFX     1'b0
`define LCDII_RST_LSEL    2'h0

`endif

/* File: logic/lcdii_pkg.sv */
// types shared by the lcd instruction interpreter
package lcdii_pkg;

	typedef enum logic [2:0]
	{
		TGT_CHAR,
		TGT_PAT,
		TGT_ICON,
		TGT_GFX
	} lcdii_tgt_t;

	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_CLEAR,
		ST_EXEC
	} lcdii_state_t;

	typedef struct packed
	{
		logic       valid;
		logic       rs;
		logic [7:0] data;
	} lcdii_byte_t;

endpackage : lcdii_pkg

/* File: logic/lcdii_nib.sv */
// joins host writes into bytes, two nibbles high first in 4-bit mode
module lcdii_nib
(
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	input  wire logic              stb_in,
	input  wire logic              rs_in,
	input  wire logic              wide_in,
	input  wire logic [7:0]        data_in,
	output lcdii_pkg::lcdii_byte_t byte_out
);
	import lcdii_pkg::*;

	logic       pend_q;
	logic [3:0] hi_q;

	wire take_hi  = stb_in & ~wide_in & ~pend_q;
	wire complete = stb_in & (wide_in | pend_q);

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pend_q <= 1'b0;
			hi_q   <= 4'h0;
		end
		else if (take_hi)
		begin
			pend_q <= 1'b1;
			hi_q   <= data_in[3:0];
		end
		else if (complete)
			pend_q <= 1'b0;
	end

	assign byte_out = {complete, rs_in, wide_in ? data_in : {hi_q, data_in[3:0]}};

endmodule : lcdii_nib

/* File: logic/lcdii_top.sv */
// lcd instruction interpreter with apb access to instruction and data ports
`include "lcdii_defines.svh"

module lcdii_top
(
	input  wire logic        SYS_CLK_IN,
	input  wire logic        RESET_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [7:0]  PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	output logic             BUSY_OUT
);
	import lcdii_pkg::*;

	function automatic logic [3:0] msb_pos(input logic [7:0] v);
		logic [3:0] p;
		p = 4'h8;
		for (int i = 0; i < 8; i++)
			if (v[i])
				p = 4'(i);
		return p;
	endfunction : msb_pos

	lcdii_state_t state_q, state_d;
	lcdii_tgt_t   tgt_q, tgt_d;
	logic [`LCDII_CNT_W-1:0] cnt_q, cnt_d;
	logic [5:0]  clr_q, clr_d;
	logic [6:0]  ac_q, ac_d;
	logic        id_q, id_d, sh_q, sh_d;
	logic        disp_q, disp_d, cur_q, cur_d, blink_q, blink_d;
	logic        dl_q, dl_d, re_q, re_d, sr_q, sr_d;
	logic        wake_q, wake_d, gfx_q, gfx_d, stby_q, stby_d;
	logic [3:0]  rev_q, rev_d;
	logic [1:0]  lsel_q, lsel_d;
	logic [5:0]  scroll_q, scroll_d, dshift_q, dshift_d;
	logic        dummy_q, dummy_d, whalf_q, whalf_d, rhalf_q, rhalf_d;
	logic        gsec_q, gsec_d;
	logic [7:0]  hi_q, hi_d;
	logic [15:0] cram [0:63];
	lcdii_byte_t nb;

	wire busy      = state_q != ST_IDLE;
	wire setup_acc = PSEL_IN & PENABLE_IN & ~PREADY_OUT;
	wire done      = PSEL_IN & PENABLE_IN & PREADY_OUT & ~PSLVERR_OUT;
	wire sel_cmd   = PADDR_IN == `LCDII_OFS_CMD;
	wire sel_data  = PADDR_IN == `LCDII_OFS_DATA;
	wire sel_flags = PADDR_IN == `LCDII_OFS_FLAGS;
	wire mapped    = sel_cmd | sel_data | sel_flags;
	wire err_d     = ~mapped | (sel_flags & PWRITE_IN)
	               | (busy & (PWRITE_IN | sel_data) & (sel_cmd | sel_data));
	wire wr_stb    = done & PWRITE_IN & (sel_cmd | sel_data);
	wire rd_go     = done & ~PWRITE_IN & sel_data & ~busy;

	lcdii_nib u_nib
	(
		.clk_in  (SYS_CLK_IN),
		.rst_in  (RESET_IN),
		.stb_in  (wr_stb),
		.rs_in   (sel_data),
		.wide_in (dl_q),
		.data_in (PWDATA_IN[7:0]),
		.byte_out(nb)
	);

	wire [7:0] dat    = nb.data;
	wire       st_idl = state_q == ST_IDLE;
	wire       ins_go = st_idl & nb.valid & ~nb.rs;
	wire       dwr_go = st_idl & nb.valid & nb.rs;
	wire       dec_ok = ins_go & ~gsec_q;
	wire [3:0] top    = msb_pos(dat);
	wire       go_clr = dec_ok & ~re_q & (top == 4'h0);
	wire       go_hom = dec_ok & ~re_q & (top == 4'h1);
	wire       go_ent = dec_ok & ~re_q & (top == 4'h2);
	wire       go_dsp = dec_ok & ~re_q & (top == 4'h3);
	wire       go_shf = dec_ok & ~re_q & (top == 4'h4);
	wire       go_fun = dec_ok & (top == 4'h5);
	wire       go_pat = dec_ok & ~re_q & (top == 4'h6);
	wire       go_ddr = dec_ok & ~re_q & (top == 4'h7);
	wire       go_sby = dec_ok & re_q & (top == 4'h0);
	wire       go_sr  = dec_ok & re_q & (top == 4'h1);
	wire       go_rev = dec_ok & re_q & (top == 4'h2);
	wire       go_slp = dec_ok & re_q & (top == 4'h3);
	wire       go_isa = dec_ok & re_q & (top == 4'h6);
	wire       go_gfa = dec_ok & re_q & (top == 4'h7);
	wire       go_hor = ins_go & gsec_q;
	wire       adr_set = go_ddr | go_pat | (go_isa & ~sr_q) | go_gfa | go_hor;
	wire       ram_we = dwr_go & whalf_q & (tgt_q == TGT_CHAR);
	wire       w_step = dwr_go & whalf_q;
	wire       r_step = rd_go & ~dummy_q & rhalf_q;
	wire       step   = w_step | r_step;
	wire       start  = nb.valid & st_idl | rd_go;

	wire [15:0] word    = cram[ac_q[5:0]];
	wire [7:0]  rd_byte = (dummy_q | (tgt_q != TGT_CHAR)) ? 8'h00 :
	                      (rhalf_q ? word[7:0] : word[15:8]);
	wire [28:0] flags   = {dshift_q, scroll_q, lsel_q, rev_q, stby_q, gfx_q,
	                       wake_q, sr_q, re_q, dl_q, sh_q, id_q, blink_q, cur_q, disp_q};
	wire [31:0] rd_mux  = sel_cmd  ? {24'h00_0000, busy, ac_q} :
	                      sel_data ? {24'h00_0000, rd_byte} :
	                      sel_flags ? {3'h0, flags} : 32'h0000_0000;

	always_comb
	begin
		state_d  = state_q;
		tgt_d    = tgt_q;
		{cnt_d, clr_d, ac_d} = {cnt_q, clr_q, ac_q};
		{id_d, sh_d, disp_d, cur_d, blink_d} = {id_q, sh_q, disp_q, cur_q, blink_q};
		{dl_d, re_d, sr_d} = {dl_q, re_q, sr_q};
		{wake_d, gfx_d, stby_d} = {wake_q, gfx_q, stby_q};
		{rev_d, lsel_d} = {rev_q, lsel_q};
		{scroll_d, dshift_d, hi_d} = {scroll_q, dshift_q, hi_q};
		{dummy_d, whalf_d, rhalf_d, gsec_d} = {dummy_q, whalf_q, rhalf_q, gsec_q};
		if (ins_go)
		begin
			stby_d = go_sby;
			gsec_d = go_gfa;
		end
		if (go_clr)
		begin
			ac_d     = 7'h00;
			id_d     = 1'b1;
			tgt_d    = TGT_CHAR;
			dshift_d = 6'h00;
		end
		if (go_hom)
		begin
			ac_d     = 7'h00;
			tgt_d    = TGT_CHAR;
			dshift_d = 6'h00;
		end
		if (go_ent)
		begin
			id_d = dat[1];
			sh_d = dat[0];
		end
		if (go_dsp)
		begin
			disp_d  = dat[2];
			cur_d   = dat[1];
			blink_d = dat[0];
		end
		if (go_shf)
		begin
			if (!dat[3])
				ac_d = dat[2] ? ac_q + 7'h01 : ac_q - 7'h01;
			else
				dshift_d = dat[2] ? dshift_q - 6'h01 : dshift_q + 6'h01;
		end
		if (go_fun)
		begin
			dl_d = dat[4];
			re_d = dat[2];
			if (re_q)
				gfx_d = dat[1];
		end
		if (go_pat)
		begin
			ac_d  = {1'b0, dat[5:0]};
			tgt_d = TGT_PAT;
		end
		if (go_ddr)
		begin
			ac_d  = dat[6:0];
			tgt_d = TGT_CHAR;
		end
		if (go_sr)
			sr_d = dat[0];
		if (go_rev)
		begin
			lsel_d = dat[1:0];
			rev_d[dat[1:0]] = ~rev_q[dat[1:0]];
		end
		if (go_slp)
			wake_d = dat[2];
		if (go_isa)
		begin
			if (sr_q)
				scroll_d = dat[5:0];
			else
			begin
				ac_d  = {3'h0, dat[3:0]};
				tgt_d = TGT_ICON;
			end
		end
		if (go_gfa)
		begin
			ac_d  = dat[6:0];
			tgt_d = TGT_GFX;
		end
		if (go_hor)
			ac_d = {3'h0, dat[3:0]};
		if (adr_set)
		begin
			dummy_d = 1'b1;
			whalf_d = 1'b0;
			rhalf_d = 1'b0;
		end
		if (dwr_go)
		begin
			whalf_d = ~whalf_q;
			if (!whalf_q)
				hi_d = dat;
		end
		if (rd_go)
		begin
			if (dummy_q)
				dummy_d = 1'b0;
			else
				rhalf_d = ~rhalf_q;
		end
		if (step)
		begin
			if (tgt_q == TGT_GFX)
				ac_d = {ac_q[6:4], ac_q[3:0] + 4'h1};
			else
			begin
				ac_d = id_q ? ac_q + 7'h01 : ac_q - 7'h01;
				if (sh_q)
					dshift_d = id_q ? dshift_q + 6'h01 : dshift_q - 6'h01;
			end
		end
		case (state_q)
			ST_IDLE:
			begin
				if (start)
				begin
					state_d = go_clr ? ST_CLEAR : ST_EXEC;
					cnt_d   = `LCDII_CNT_W'(`LCDII_EXEC_CYC - 1);
					clr_d   = 6'h00;
				end
			end
			ST_CLEAR:
			begin
				clr_d = clr_q + 6'h01;
				if (clr_q == `LCDII_CRAM_LAST)
					state_d = ST_EXEC;
			end
			ST_EXEC:
			begin
				cnt_d = cnt_q - `LCDII_CNT_W'(1);
				if (cnt_q == '0)
					state_d = ST_IDLE;
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK_IN)
	begin
		if (state_q == ST_CLEAR)
			cram[clr_q] <= `LCDII_SPACE_WORD;
		else if (ram_we)
			cram[ac_q[5:0]] <= {hi_q, dat};
	end

	always_ff @(posedge SYS_CLK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			PRDATA_OUT  <= 32'h0000_0000;
			PREADY_OUT  <= 1'b0;
			PSLVERR_OUT <= 1'b0;
			BUSY_OUT    <= 1'b0;
		end
		else
		begin
			PREADY_OUT <= setup_acc;
			BUSY_OUT   <= state_d != ST_IDLE;
			if (setup_acc)
			begin
				PRDATA_OUT  <= PWRITE_IN ? 32'h0000_0000 : rd_mux;
				PSLVERR_OUT <= err_d;
			end
		end
	end

	always_ff @(posedge SYS_CLK_IN or posedge RESET_IN)
	begin
		if (RESET_IN)
		begin
			state_q <= ST_IDLE;
			tgt_q   <= TGT_CHAR;
			{cnt_q, clr_q, ac_q} <= 24'h00_0000;
			{id_q, sh_q, disp_q, cur_q, blink_q} <= {`LCDII_RST_ID, 4'h0};
			{dl_q, re_q, sr_q} <= {`LCDII_RST_DL, `LCDII_RST_RE, `LCDII_RST_SR};
			{wake_q, gfx_q, stby_q} <= {`LCDII_RST_WAKE, `LCDII_RST_GFX, 1'b0};
			{rev_q, lsel_q} <= {4'h0, `LCDII_RST_LSEL};
			{scroll_q, dshift_q, hi_q} <= 20'h0_0000;
			{dummy_q, whalf_q, rhalf_q, gsec_q} <= 4'h0;
		end
		else
		begin
			state_q  <= state_d;
			tgt_q    <= tgt_d;
			{cnt_q, clr_q, ac_q} <= {cnt_d, clr_d, ac_d};
			{id_q, sh_q, disp_q, cur_q, blink_q} <= {id_d, sh_d, disp_d, cur_d, blink_d};
			{dl_q, re_q, sr_q} <= {dl_d, re_d, sr_d};
			{wake_q, gfx_q, stby_q} <= {wake_d, gfx_d, stby_d};
			{rev_q, lsel_q} <= {rev_d, lsel_d};
			{scroll_q, dshift_q, hi_q} <= {scroll_d, dshift_d, hi_d};
			{dummy_q, whalf_q, rhalf_q, gsec_q} <= {dummy_d, whalf_d, rhalf_d, gsec_d};
		end
	end

	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (RESET_IN);

	a_clear_origin: assert property (go_clr |=> ac_q == 7'h00 && id_q)
		else $error("clear did not zero counter or set increment");
	a_home_origin: assert property (go_hom |=> ac_q == 7'h00)
		else $error("home did not zero counter");
	a_step_dir: assert property (w_step && tgt_q == TGT_CHAR |=>
		ac_q == ($past(id_q) ? $past(ac_q) + 7'h01 : $past(ac_q) - 7'h01))
		else $error("counter step wrong after word write");
	a_busy_hold: assert property ($rose(BUSY_OUT) |-> BUSY_OUT[*8])
		else $error("busy dropped early");
	a_busy_reject: assert property (setup_acc && PWRITE_IN && sel_cmd && busy
		|=> PSLVERR_OUT && !ins_go)
		else $error("instruction not refused while busy");
	a_rev_toggle: assert property (go_rev |=> $countones(rev_q ^ $past(rev_q)) == 1)
		else $error("reverse did not toggle one line");
	a_wake_bit: assert property (go_slp |=> wake_q == $past(dat[2]))
		else $error("sleep bit not taken");
	a_gfx_wrap: assert property (w_step && tgt_q == TGT_GFX |=>
		ac_q[3:0] == $past(ac_q[3:0]) + 4'h1 && ac_q[6:4] == $past(ac_q[6:4]))
		else $error("graphic address step wrong");
	a_dummy_set: assert property (adr_set |=> dummy_q && !whalf_q && !rhalf_q)
		else $error("dummy read not armed after address set");
	a_standby_end: assert property (stby_q && ins_go && !go_sby |=> !stby_q)
		else $error("standby not ended by instruction");

endmodule : lcdii_top

/* File: verif/lcdii_host.sv */
// apb master model standing in for the host processor
module lcdii_host
(
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        go_in,
	input  wire logic        wr_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        pready_in,
	output logic             psel_out,
	output logic             penable_out,
	output logic             pwrite_out,
	output logic      [7:0]  paddr_out,
	output logic      [31:0] pwdata_out,
	output logic             done_out
);
	timeunit 1ns;
	timeprecision 1ps;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			psel_out    <= 1'b0;
			penable_out <= 1'b0;
			pwrite_out  <= 1'b0;
			paddr_out   <= 8'h00;
			pwdata_out  <= 32'h0000_0000;
			done_out    <= 1'b0;
		end
		else
		begin
			done_out <= 1'b0;
			if (psel_out && penable_out && pready_in)
			begin
				// released data lines show a changed value, never the last one
				psel_out    <= 1'b0;
				penable_out <= 1'b0;
				pwdata_out  <= ~pwdata_out;
				done_out    <= 1'b1;
			end
			else if (psel_out)
				penable_out <= 1'b1;
			else if (go_in)
			begin
				psel_out   <= 1'b1;
				pwrite_out <= wr_in;
				paddr_out  <= addr_in;
				pwdata_out <= wdata_in;
			end
		end
	end
endmodule : lcdii_host

/* File: verif/test_lcd_instruction_interpreter.sv */
// self-checking bench of the lcd instruction interpreter
`include "lcdii_defines.svh"

module test_lcd_instruction_interpreter;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk;
	logic        rst;
	logic        go;
	logic        wr;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        psel;
	logic        pen;
	logic        pwr;
	logic [7:0]  pa;
	logic [31:0] pwd;
	logic        done;
	logic [31:0] prdata;
	logic        pready;
	logic        perr;
	logic        busy;
	logic [64:0] exp_q[$];
	logic [64:0] ent;
	logic [31:0] f;
	logic [7:0]  r;
	logic [7:0]  d1;
	logic [7:0]  d2;
	int          bad_count;
	int          total_checks;
	int          i;

	lcdii_top dut_u
	(
		.SYS_CLK_IN  (clk),
		.RESET_IN    (rst),
		.PSEL_IN     (psel),
		.PENABLE_IN  (pen),
		.PWRITE_IN   (pwr),
		.PADDR_IN    (pa),
		.PWDATA_IN   (pwd),
		.PRDATA_OUT  (prdata),
		.PREADY_OUT  (pready),
		.PSLVERR_OUT (perr),
		.BUSY_OUT    (busy)
	);

	lcdii_host host_u
	(
		.clk_in      (clk),
		.rst_in      (rst),
		.go_in       (go),
		.wr_in       (wr),
		.addr_in     (addr),
		.wdata_in    (wdata),
		.pready_in   (pready),
		.psel_out    (psel),
		.penable_out (pen),
		.pwrite_out  (pwr),
		.paddr_out   (pa),
		.pwdata_out  (pwd),
		.done_out    (done)
	);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// each answered transfer takes the oldest note: {error, mask, value}
	always @(posedge clk)
	begin
		if (psel && pen && pready === 1'b1)
		begin
			ent = exp_q.pop_front();
			total_checks++;
			if ({perr, prdata & ent[63:32]} !== {ent[64], ent[31:0]})
			begin
				bad_count++;
				$display("CHECK FAILED apb %h expected %h seen %h", pa,
					{ent[64], ent[31:0]}, {perr, prdata & ent[63:32]});
			end
		end
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic [32:0] e);
		int n;
		exp_q.push_back({e[32], m, e[31:0] & m});
		go    <= 1'b1;
		wr    <= w;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		if (n == 20)
			bad_count++;
	endtask : xfer

	// host waits for the busy flag to drop before its next request
	task automatic idle;
		int n;
		n = 0;
		repeat (2) @(posedge clk);
		while (busy !== 1'b0 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		if (n == 3000)
			bad_count++;
	endtask : idle

	task automatic cmd(input logic [7:0] c);
		xfer(1'b1, `LCDII_OFS_CMD, 32'(c), '0, '0);
		idle;
	endtask : cmd

	task automatic wrd(input logic [7:0] c);
		xfer(1'b1, `LCDII_OFS_DATA, 32'(c), '0, '0);
		idle;
	endtask : wrd

	task automatic st(input logic [7:0] e);
		xfer(1'b0, `LCDII_OFS_CMD, '0, 32'h0000_00FF, 33'(e));
	endtask : st

	task automatic rdd(input logic [7:0] e);
		xfer(1'b0, `LCDII_OFS_DATA, '0, 32'h0000_00FF, 33'(e));
		idle;
	endtask : rdd

	task automatic fl;
		xfer(1'b0, `LCDII_OFS_FLAGS, '0, 32'h1FFF_FFFF, {1'b0, f});
	endtask : fl

	task automatic cf(input logic [7:0] c, input logic [31:0] t);
		cmd(c);
		f = f ^ t;
		fl;
	endtask : cf

	initial
	begin
		#5_000_000;
		bad_count++;
		end_sim;
	end

	initial
	begin
		rst = 1'b1;
		go = 1'b0;
		wr = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		void'($urandom(32'h2be7));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		f = 32'h0000_0128;
		fl;
		cf(8'h04, 32'h0000_0008);
		cf(8'h01, 32'h0000_0008);
		st(8'h00);
		cmd(8'h80);
		rdd(8'h00);
		rdd(8'h20);
		rdd(8'h20);
		st(8'h01);
		for (i = 0; i < 4; i++)
		begin
			r = 8'h80 + 8'(16 * i) + 8'($urandom % 14);
			cmd(r);
			st({1'b0, r[6:0]});
		end
		d1 = 8'($urandom);
		d2 = 8'($urandom);
		wrd(d1);
		st({1'b0, r[6:0]});
		wrd(d2);
		st({1'b0, r[6:0]} + 8'h01);
		cmd(r);
		rdd(8'h00);
		rdd(d1);
		rdd(d2);
		cf(8'h04, 32'h0000_0008);
		wrd(d1);
		wrd(d2);
		st({1'b0, r[6:0]});
		cmd(8'h07);
		wrd(d1);
		wrd(d2);
		f = f ^ 32'h0080_0018;
		fl;
		cf(8'h02, 32'h0080_0000);
		st(8'h00);
		for (i = 0; i < 3; i++)
		begin
			r = 8'($urandom % 8);
			cmd(8'h08 | r);
			f[2:0] = {r[0], r[1], r[2]};
			fl;
		end
		xfer(1'b1, `LCDII_OFS_CMD, 32'h0000_0014, '0, '0);
		repeat (`LCDII_EXEC_CYC + 2) @(posedge clk);
		st(8'h01);
		cmd(8'h10);
		st(8'h00);
		cmd(8'h14);
		st(8'h01);
		cmd(8'h10);
		st(8'h00);
		cf(8'h18, 32'h0080_0000);
		cf(8'h1C, 32'h0080_0000);
		cmd(8'h7F);
		st(8'h3F);
		xfer(1'b1, `LCDII_OFS_CMD, 32'h0000_0002, '0, '0);
		xfer(1'b1, `LCDII_OFS_CMD, 32'h0000_007F, '0, 33'h1_0000_0000);
		xfer(1'b0, `LCDII_OFS_CMD, '0, 32'h0000_0080, 33'h0_0000_0080);
		idle;
		st(8'h00);
		xfer(1'b0, 8'h0C, '0, '0, 33'h1_0000_0000);
		xfer(1'b1, `LCDII_OFS_FLAGS, '0, '0, 33'h1_0000_0000);
		cf(8'h34, 32'h0000_0040);
		cf(8'h04, 32'h0000_0800);
		cf(8'h04, 32'h0000_0800);
		cf(8'h07, 32'h0001_C000);
		cf(8'h08, 32'h0000_0100);
		cf(8'h0C, 32'h0000_0100);
		cf(8'h01, 32'h0000_0400);
		cf(8'h03, 32'h0000_0480);
		r = 8'($urandom % 64);
		cmd(8'h40 | r);
		f[22:17] = r[5:0];
		fl;
		cf(8'h02, 32'h0000_0080);
		cmd(8'h4F);
		xfer(1'b0, `LCDII_OFS_CMD, '0, 32'h0000_000F, 33'h0_0000_000F);
		cf(8'h36, 32'h0000_0200);
		cmd(8'h80 | 8'($urandom % 128));
		cmd(8'h0F);
		xfer(1'b0, `LCDII_OFS_CMD, '0, 32'h0000_000F, 33'h0_0000_000F);
		wrd(d1);
		wrd(d2);
		xfer(1'b0, `LCDII_OFS_CMD, '0, 32'h0000_000F, 33'h0_0000_0000);
		cf(8'h34, 32'h0000_0200);
		cf(8'h30, 32'h0000_0040);
		cf(8'h20, 32'h0000_0020);
		xfer(1'b1, `LCDII_OFS_CMD, 32'h0000_0003, '0, '0);
		repeat (3) @(posedge clk);
		total_checks++;
		if (busy !== 1'b0)
		begin
			bad_count++;
			$display("CHECK FAILED busy expected 0 seen %b", busy);
		end
		cf(8'h00, 32'h0000_0020);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		f = 32'h0000_0128;
		fl;
		end_sim;
	end
endmodule : test_lcd_instruction_interpreter
